// >>> core/usbep_ctrl.sv
// endpoint control registers, token admission and axi4-lite slave
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module usbep_ctrl (
    input wire logic clk, // 25 MHz clock
    input wire logic reset, // sync reset, active high
    input wire logic [7:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [7:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic hostMode, // module acts as usb host
    input wire logic lowSpeedTarget, // host talks to a low-speed device
    input wire logic tokenValid, // token pulse
    input usbep_pkg::usbep_token_e tokenKind, // token type
    input wire logic [3:0] tokenEp, // token endpoint
    input wire logic stallReq, // protocol engine stalls stallEp
    input wire logic [3:0] stallEp, // endpoint being stalled
    input wire logic nakSeen, // host: nak received on ep0
    output logic respValid, // decision pulse
    output logic respAccept, // transfer admitted
    output logic respHandshake, // handshake phase used
    output logic respStall, // answer with stall handshake
    output logic preambleReq, // send preamble through hub
    output logic retryReq, // reissue nak'd transaction
    output logic irq // level interrupt
);
    logic [7:0] epCtrl [usbep_pkg::EP_COUNT];
    logic [usbep_pkg::EVT_W-1:0] evtStatus;
    logic [usbep_pkg::EVT_W-1:0] evtMask;
    logic [usbep_pkg::EVT_W-1:0] evtSet;
    logic [usbep_pkg::EP_COUNT-1:0] stallSet;
    logic [7:0] tokCtrl;
    logic [7:0] ep0;
    logic gateAccept;
    logic gateHshk;
    logic refused;
    logic wrFire;
    logic rdFire;
    logic wrIsEp;
    logic rdIsEp;
    logic [3:0] wrIdx;
    logic [3:0] rdIdx;
    logic wrMapped;
    logic rdMapped;
    logic statusRead;
    logic [31:0] next_rdata;

    assign ep0 = epCtrl[0];
    assign tokCtrl = epCtrl[tokenEp];

    usbep_gate uGate (
        .ctrl(tokCtrl),
        .kind(tokenKind),
        .accept(gateAccept),
        .handshake(gateHshk)
    );

    assign refused = tokenValid && !gateAccept;

    // address decode; low two bits are ignored, registers are word aligned
    assign wrIsEp = (awaddr[7:6] == usbep_pkg::EP_BASE_OFF[7:6]);
    assign rdIsEp = (araddr[7:6] == usbep_pkg::EP_BASE_OFF[7:6]);
    assign wrIdx = awaddr[5:2];
    assign rdIdx = araddr[5:2];
    assign wrMapped = wrIsEp
        || (awaddr[7:2] == usbep_pkg::STATUS_OFF[7:2])
        || (awaddr[7:2] == usbep_pkg::MASK_OFF[7:2]);
    assign rdMapped = rdIsEp
        || (araddr[7:2] == usbep_pkg::STATUS_OFF[7:2])
        || (araddr[7:2] == usbep_pkg::MASK_OFF[7:2]);

    // both channels are taken together, so one fire covers address and data
    assign wrFire = awvalid && awready;
    assign rdFire = arvalid && arready;
    assign statusRead = rdFire && (araddr[7:2] == usbep_pkg::STATUS_OFF[7:2]);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            awready <= 1'b0;
            wready <= 1'b0;
        end
        else
        begin
            awready <= awvalid && wvalid && !awready && !bvalid;
            wready <= awvalid && wvalid && !awready && !bvalid;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bvalid <= 1'b0;
            bresp <= usbep_pkg::RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid <= 1'b1;
            bresp <= wrMapped ? usbep_pkg::RESP_OKAY : usbep_pkg::RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            arready <= 1'b0;
        end
        else
        begin
            arready <= arvalid && !arready && !rvalid;
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (rdIsEp)
        begin
            next_rdata[7:0] = epCtrl[rdIdx] & usbep_pkg::EP_IMPL_MASK;
        end
        else if (araddr[7:2] == usbep_pkg::STATUS_OFF[7:2])
        begin
            next_rdata[usbep_pkg::EVT_W-1:0] = evtStatus;
        end
        else if (araddr[7:2] == usbep_pkg::MASK_OFF[7:2])
        begin
            next_rdata[usbep_pkg::EVT_W-1:0] = evtMask;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= usbep_pkg::RESP_OKAY;
        end
        else if (rdFire)
        begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rdMapped ? usbep_pkg::RESP_OKAY : usbep_pkg::RESP_SLVERR;
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // a refused token with handshakes on is answered by stall
    for (genvar i = 0; i < usbep_pkg::EP_COUNT; i++)
    begin : gEp
        assign stallSet[i] = (stallReq && stallEp == i)
            || (refused && gateHshk && tokenEp == i);

        always_ff @(posedge clk)
        begin
            if (reset)
            begin
                epCtrl[i] <= usbep_pkg::EP_RESET;
            end
            else
            begin
                if (wrFire && wrIsEp && wrIdx == i && wstrb[0])
                begin
                    epCtrl[i] <= wdata[7:0] & usbep_pkg::EP_IMPL_MASK;
                end
                // hardware set wins over a software clear in the same cycle
                if (stallSet[i])
                begin
                    epCtrl[i][usbep_pkg::STALL_BIT] <= 1'b1;
                end
            end
        end
    end

    // token answer, one cycle after the token
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            respValid <= 1'b0;
            respAccept <= 1'b0;
            respHandshake <= 1'b0;
            respStall <= 1'b0;
        end
        else
        begin
            respValid <= tokenValid;
            respAccept <= tokenValid && gateAccept;
            respHandshake <= tokenValid && gateHshk;
            respStall <= refused && gateHshk;
        end
    end

    // host-only ep0 options; meaningless in device mode so gated off there
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            preambleReq <= 1'b0;
            retryReq <= 1'b0;
        end
        else
        begin
            preambleReq <= hostMode && tokenValid && tokenEp == 4'h0
                && lowSpeedTarget && !ep0[usbep_pkg::LOW_SPEED_DIRECT_BIT];
            retryReq <= hostMode && nakSeen && !ep0[usbep_pkg::RETRY_DIS_BIT];
        end
    end

    assign evtSet[usbep_pkg::EVT_STALL] = |stallSet;
    assign evtSet[usbep_pkg::EVT_REFUSE] = refused;
    assign evtSet[usbep_pkg::EVT_NAKSTOP] = hostMode && nakSeen
        && ep0[usbep_pkg::RETRY_DIS_BIT];

    // read of status clears it; a new event in that cycle survives
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            evtStatus <= usbep_pkg::EVT_RESET;
        end
        else if (statusRead)
        begin
            evtStatus <= evtSet;
        end
        else
        begin
            evtStatus <= evtStatus | evtSet;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            evtMask <= usbep_pkg::MASK_RESET;
        end
        else if (wrFire && wstrb[0] && awaddr[7:2] == usbep_pkg::MASK_OFF[7:2])
        begin
            evtMask <= wdata[usbep_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(evtStatus & evtMask);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    ep_read_zero_a: assert property (
        rdFire && rdIsEp |=> rvalid && rdata[31:8] == 24'h00_0000 && !rdata[5])
        else $error("endpoint read shows unimplemented bits");

    out_gate_a: assert property (
        tokenValid && tokenKind == usbep_pkg::TOK_OUT
        && !tokCtrl[usbep_pkg::RX_EN_BIT] |=> respValid && !respAccept)
        else $error("out accepted with receive disabled");

    in_gate_a: assert property (
        tokenValid && tokenKind == usbep_pkg::TOK_IN
        |=> respAccept == $past(tokCtrl[usbep_pkg::TX_EN_BIT]))
        else $error("in admission does not follow transmit enable");

    setup_refuse_a: assert property (
        tokenValid && tokenKind == usbep_pkg::TOK_SETUP
        && tokCtrl[4:2] == 3'h7 |=> !respAccept)
        else $error("setup accepted with control transfers disabled");

    setup_single_a: assert property (
        tokenValid && tokenKind == usbep_pkg::TOK_SETUP
        && tokCtrl[4:2] == 3'h6 |=> respAccept)
        else $error("setup refused although disable bit is ignored");

    no_handshake_a: assert property (
        tokenValid && !tokCtrl[usbep_pkg::HSHK_BIT]
        |=> !respHandshake && !respStall)
        else $error("handshake used while disabled");

    stall_flag_a: assert property (
        stallReq |=> epCtrl[$past(stallEp)][usbep_pkg::STALL_BIT])
        else $error("stall flag not set");

    nak_retry_a: assert property (
        hostMode && nakSeen |=> retryReq == !$past(ep0[usbep_pkg::RETRY_DIS_BIT]))
        else $error("nak retry does not follow retry disable");

    preamble_a: assert property (
        hostMode && tokenValid && tokenEp == 4'h0 && lowSpeedTarget
        |=> preambleReq == !$past(ep0[usbep_pkg::LOW_SPEED_DIRECT_BIT]))
        else $error("preamble does not follow low-speed direct");

    ep_write_a: assert property (
        wrFire && wrIsEp && wstrb[0]
        |=> (epCtrl[$past(wrIdx)] & 8'hDD) == ($past(wdata[7:0]) & 8'hDD))
        else $error("endpoint register write lost");

    irq_level_a: assert property (
        (|(evtStatus & evtMask)) |=> irq)
        else $error("interrupt not raised");

    write_seen_c: cover property (wrFire ##1 bvalid);
    stall_irq_c: cover property (stallReq ##[1:4] irq);
    retry_c: cover property (retryReq);
endmodule : usbep_ctrl

// >>> core/usbep_pkg.sv
// constants and types for the usb endpoint control block
// Contract
// - host ep0 direct low-speed else hub preamble
// - host ep0 retry-disable stops automatic nak retry
// - both directions: disable bit refuses setup transfers
// - disable bit ignored unless tx and rx
// - out accepted only while receive enabled
// - in serviced only while transmit enabled
// - stall sets flag, reads zero otherwise; here a register write with bit 1 set also sets the flag
// - handshakes only while handshake enable set
// - bits 31-8 and 5 read zero
package usbep_pkg;
    localparam int EP_COUNT = 16;
    localparam int ADDR_W = 8;
    // register byte addresses
    localparam logic [7:0] EP_BASE_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h40;
    localparam logic [7:0] MASK_OFF = 8'h44;
    // endpoint control field positions
    localparam int LOW_SPEED_DIRECT_BIT = 7;
    localparam int RETRY_DIS_BIT = 6;
    localparam int CTL_DIS_BIT = 4;
    localparam int RX_EN_BIT = 3;
    localparam int TX_EN_BIT = 2;
    localparam int STALL_BIT = 1;
    localparam int HSHK_BIT = 0;
    localparam logic [7:0] EP_IMPL_MASK = 8'hDF;
    localparam logic [7:0] EP_RESET = 8'h00;
    // event status bits
    localparam int EVT_W = 3;
    localparam int EVT_STALL = 0;
    localparam int EVT_REFUSE = 1;
    localparam int EVT_NAKSTOP = 2;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} usbep_token_e;
endpackage : usbep_pkg

// >>> core/usbep_gate.sv
// per-token admission decision for one endpoint control value
`timescale 1ns/1ps
module usbep_gate (
    input wire logic [7:0] ctrl, // endpoint control value
    input usbep_pkg::usbep_token_e kind, // token type
    output logic accept, // transfer allowed
    output logic handshake // handshake phase used
);
    logic rxEn;
    logic txEn;
    logic bothDir;

    assign rxEn = ctrl[usbep_pkg::RX_EN_BIT];
    assign txEn = ctrl[usbep_pkg::TX_EN_BIT];
    assign bothDir = rxEn && txEn;
    assign handshake = ctrl[usbep_pkg::HSHK_BIT];

    always_comb
    begin
        case (kind)
            usbep_pkg::TOK_OUT: accept = rxEn;
            usbep_pkg::TOK_IN: accept = txEn;
            usbep_pkg::TOK_SETUP:
                accept = rxEn && !(bothDir && ctrl[usbep_pkg::CTL_DIS_BIT]);
            default: accept = 1'b0;
        endcase
    end
endmodule : usbep_gate

// >>> bench/usbep_host_model.sv
// usb bus partner model: issues tokens, stalls and naks and captures the decisions
`timescale 1ns/1ps
module usbep_host_model (
    input wire logic clk, // 25 MHz clock
    output logic tokenValid, // token pulse
    output usbep_pkg::usbep_token_e tokenKind, // token type
    output logic [3:0] tokenEp, // token endpoint
    output logic stallReq, // stall pulse
    output logic [3:0] stallEp, // stalled endpoint
    output logic nakSeen, // nak pulse
    input wire logic respValid, // decision pulse
    input wire logic respAccept, // transfer admitted
    input wire logic respHandshake, // handshake used
    input wire logic respStall, // stall answer
    input wire logic preambleReq, // preamble request
    input wire logic retryReq // retry request
);
    logic [5:0] seen;
    initial
    begin
        tokenValid = 1'b0;
        tokenKind = usbep_pkg::TOK_OUT;
        tokenEp = 4'h0;
        stallReq = 1'b0;
        stallEp = 4'h0;
        nakSeen = 1'b0;
        seen = 6'h00;
    end
    // op 0 token, 1 stall, 2 nak; decisions stand one cycle, so they are caught after the edge
    task automatic issue(input int op, input usbep_pkg::usbep_token_e k, input logic [3:0] ep);
        @(posedge clk);
        tokenValid <= (op == 0);
        stallReq <= (op == 1);
        nakSeen <= (op == 2);
        tokenKind <= k;
        tokenEp <= ep;
        stallEp <= ep;
        @(posedge clk);
        tokenValid <= 1'b0;
        stallReq <= 1'b0;
        nakSeen <= 1'b0;
        // released fields change so a stale value is never read as live
        tokenEp <= ~ep;
        stallEp <= ~ep;
        #1;
        seen = {respValid, respAccept, respHandshake, respStall, preambleReq, retryReq};
    endtask : issue
endmodule : usbep_host_model

// >>> bench/usb_endpoint_control_tb.sv
// self-checking bench for the endpoint control block
`timescale 1ns/1ps
module usb_endpoint_control_tb;
    logic clk, reset, awvalid, wvalid, bready, arvalid, rready, hostMode, lowSpeedTarget;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic tokenValid, stallReq, nakSeen, respValid, respAccept, respHandshake;
    logic respStall, preambleReq, retryReq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, tokenEp, stallEp;
    logic [1:0] bresp, rresp, rs;
    usbep_pkg::usbep_token_e tokenKind;
    int errorCnt = 0;
    int checks = 0;
    usbep_ctrl DUT (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hostMode(hostMode), .lowSpeedTarget(lowSpeedTarget), .tokenValid(tokenValid),
        .tokenKind(tokenKind), .tokenEp(tokenEp), .stallReq(stallReq), .stallEp(stallEp),
        .nakSeen(nakSeen), .respValid(respValid), .respAccept(respAccept),
        .respHandshake(respHandshake), .respStall(respStall), .preambleReq(preambleReq),
        .retryReq(retryReq), .irq(irq));
    usbep_host_model bus (.clk(clk), .tokenValid(tokenValid), .tokenKind(tokenKind),
        .tokenEp(tokenEp), .stallReq(stallReq), .stallEp(stallEp), .nakSeen(nakSeen),
        .respValid(respValid), .respAccept(respAccept), .respHandshake(respHandshake),
        .respStall(respStall), .preambleReq(preambleReq), .retryReq(retryReq));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("errors %0d checks %0d", errorCnt, checks);
        if (errorCnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released at the edge where its own ready is seen
        while (!(awDone && wDone))
        begin
            @(posedge clk);
            if (awready === 1'b1)
                awDone = 1'b1;
            if (wready === 1'b1)
                wDone = 1'b1;
            if (awDone)
                awvalid <= 1'b0;
            if (wDone)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge clk);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdw
    task automatic reset_values;
        for (int i = 0; i < 16; i++)
        begin
            rdw(8'(4 * i));
            chk("endpoint reset", 32'h0, rd);
        end
        rdw(8'h48);
        chk("unmapped resp", 32'(usbep_pkg::RESP_SLVERR), 32'(rs));
    endtask : reset_values
    task automatic reserved_bits;
        wr(8'h3C, 32'hFFFFFFFF);
        chk("write resp", 32'(usbep_pkg::RESP_OKAY), 32'(rs));
        rdw(8'h3C);
        chk("reserved read", 32'hDF, rd);
        wr(8'h3C, 32'h00000000);
        // lane 0 strobe off: the write is answered but changes nothing
        wstrb <= 4'hE;
        wr(8'h3C, 32'h000000FF);
        wstrb <= 4'hF;
        rdw(8'h3C);
        chk("strobe off", 32'h0, rd);
        wr(8'h48, 32'h0);
        chk("unmapped write resp", 32'(usbep_pkg::RESP_SLVERR), 32'(rs));
    endtask : reserved_bits
    task automatic admission_table;
        logic [7:0] c;
        logic acc;
        usbep_pkg::usbep_token_e k;
        rdw(usbep_pkg::STATUS_OFF);
        for (int i = 0; i < 48; i++)
        begin
            c = {3'h0, i[3], i[2], i[1], 1'b0, i[0]};
            k = usbep_pkg::usbep_token_e'(i / 16);
            acc = (k == usbep_pkg::TOK_OUT) ? c[3] : (k == usbep_pkg::TOK_IN) ? c[2] :
                (c[3] && !(c[2] && c[4]));
            wr(8'(4 * (i % 16)), 32'(c));
            bus.issue(0, k, 4'(i % 16));
            chk("token decision", {26'h0, 1'b1, acc, c[0], !acc && c[0], 2'b00}, 32'(bus.seen));
            rdw(8'(4 * (i % 16)));
            chk("stall flag", 32'(c | {6'h00, !acc && c[0], 1'b0}), rd);
        end
        // refused tokens with handshakes on raised both stall and refuse events
        rdw(usbep_pkg::STATUS_OFF);
        chk("token events", 32'h3, rd);
    endtask : admission_table
    task automatic stall_irq;
        wr(8'h14, 32'h0);
        rdw(usbep_pkg::STATUS_OFF);
        wr(usbep_pkg::MASK_OFF, 32'h1);
        bus.issue(1, usbep_pkg::TOK_OUT, 4'h5);
        rdw(8'h14);
        chk("stall by engine", 32'h02, rd);
        chk("irq raised", 32'h1, 32'(irq));
        rdw(usbep_pkg::STATUS_OFF);
        chk("status", 32'h1, rd);
        @(posedge clk);
        #1;
        chk("irq cleared", 32'h0, 32'(irq));
    endtask : stall_irq
    task automatic host_ep0;
        hostMode <= 1'b1;
        lowSpeedTarget <= 1'b1;
        wr(8'h00, 32'h0C);
        bus.issue(0, usbep_pkg::TOK_IN, 4'h0);
        chk("preamble via hub", 32'h1, 32'(bus.seen[1]));
        wr(8'h00, 32'h8C);
        bus.issue(0, usbep_pkg::TOK_IN, 4'h0);
        chk("direct low speed", 32'h0, 32'(bus.seen[1]));
        bus.issue(2, usbep_pkg::TOK_IN, 4'h0);
        chk("retry on nak", 32'h1, 32'(bus.seen[0]));
        wr(8'h00, 32'h4C);
        bus.issue(2, usbep_pkg::TOK_IN, 4'h0);
        chk("no retry", 32'h0, 32'(bus.seen[0]));
        rdw(usbep_pkg::STATUS_OFF);
        chk("nak stop status", 32'h4, rd & 32'h4);
        hostMode <= 1'b0;
    endtask : host_ep0
    initial
    begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        close_out();
    end
    initial
    begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, hostMode, lowSpeedTarget} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        reset_values();
        reserved_bits();
        admission_table();
        stall_irq();
        host_ep0();
        close_out();
    end
endmodule : usb_endpoint_control_tb
